// File: oscillation_stop_wait_control_bench.sv
`timescale 1ns/1ps
module oscillation_stop_wait_control_bench;
  localparam int PS = 2;
  localparam int REL_N = PS * 2048;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [oswc_pkg::WAIT_BLOCK_N-1:0] irq_blocked_i = '0;
  logic ext_int_pin_i = 1'h0;
  logic sub_clk_pin_i = 1'h0;
  logic [2:0] req = 3'h0;
  logic stop_instr_i, wait_instr_i, irq_valid_i, pready_o, pslverr_o, phi_o, err, b;
  logic cpu_clk_gated_o, main_osc_en_o, sub_drive_strong_o, timers_chained_o;
  logic resume_o, t3_ovf_o, t4_ovf_o;
  logic [1:0] clk_src_sel_o;
  logic [31:0] prdata_o, rd;
  int miscompares = 0;
  int n_compared = 0;
  int n, i;

  always #50 clk_i = ~clk_i;

  oswc_top #(.PRESCALE(PS)) i_dut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .stop_instr_i, .wait_instr_i, .irq_valid_i,
    .irq_blocked_i, .ext_int_pin_i, .sub_clk_pin_i, .phi_o, .cpu_clk_gated_o, .main_osc_en_o,
    .sub_drive_strong_o, .clk_src_sel_o, .timers_chained_o, .resume_o, .t3_ovf_o, .t4_ovf_o);
  oswc_cpu_model i_cpu (.clk_i, .rstn_i, .req_i(req), .gated_i(cpu_clk_gated_o),
    .resume_i(resume_o), .stop_instr_o(stop_instr_i), .wait_instr_o(wait_instr_i),
    .irq_valid_o(irq_valid_i));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; pready and the answer are taken at the rising edge that ends it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    w = 0;
    do
    begin
      @(posedge clk_i);
      w++;
    end
    while (pready_o !== 1'h1);
    chk("access edges", w, 2);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    req <= m;
    @(posedge clk_i);
    req <= 3'h0;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask

  task automatic gap(input logic sel, output int g);
    @(negedge clk_i);
    for (g = 1; g < 1000 && (sel ? t4_ovf_o : t3_ovf_o) !== 1'h1; g++) @(negedge clk_i);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'h1;
    repeat (4) @(negedge clk_i);
    b = phi_o;
    @(negedge clk_i);
    chk("phi", phi_o, !b);
    chk("drive", sub_drive_strong_o, 1'h1);
    apb(1'h0, oswc_pkg::CPU_MODE_OFS, 32'h0);
    chk("cpu mode", rd, 32'h3C);
    apb(1'h0, 8'h14, 32'h0);
    chk("unmapped", err, 1'h1);
    $display("test reset done");
    apb(1'h1, oswc_pkg::CPU_MODE_OFS, 32'h1C);
    settle();
    chk("drive", sub_drive_strong_o, 1'h0);
    apb(1'h1, oswc_pkg::CPU_MODE_OFS, 32'hFC);
    settle();
    chk("osc", main_osc_en_o, 1'h0);
    for (i = 1; i >= 0; i--)
    begin
      @(posedge clk_i);
      sub_clk_pin_i <= i[0];
      repeat (6) @(negedge clk_i);
      chk("phi sub", phi_o, i[0]);
    end
    apb(1'h1, oswc_pkg::CPU_MODE_OFS, 32'h3C);
    repeat (20) @(negedge clk_i);
    chk("osc", main_osc_en_o, 1'h1);
    for (i = 3; i >= 0; i--)
    begin
      apb(1'h1, oswc_pkg::CLK_SRC_OFS, 32'(i << 4));
      settle();
      chk("clk src", clk_src_sel_o, i[1:0]);
    end
    $display("test mode done");
    apb(1'h1, oswc_pkg::TMR_RELOAD_OFS, 32'h0503);
    apb(1'h1, oswc_pkg::TMR_CFG_OFS, 32'h06);
    gap(1'h0, n);
    gap(1'h0, n);
    chk("t3 period", n, 4 * PS);
    gap(1'h1, n);
    gap(1'h1, n);
    chk("t4 period", n, 6 * PS);
    $display("test timer done");
    pulse(3'h2);
    settle();
    chk("wait", {cpu_clk_gated_o, phi_o, main_osc_en_o}, 3'h7);
    @(posedge clk_i);
    irq_blocked_i <= '1;
    repeat (20) @(negedge clk_i);
    apb(1'h0, oswc_pkg::STATUS_OFS, 32'h0);
    chk("wait state", {rd[6], rd[1:0]}, 3'h5);
    chk("blocked seen", rd[31:24], 8'hFF);
    @(posedge clk_i);
    irq_blocked_i <= '0;
    pulse(3'h4);
    settle();
    chk("woken", cpu_clk_gated_o, 1'h0);
    $display("test wait done");
    apb(1'h1, oswc_pkg::TMR_CFG_OFS, 32'h0);
    apb(1'h1, oswc_pkg::CPU_MODE_OFS, 32'h3C);
    pulse(3'h1);
    repeat (40) @(negedge clk_i);
    chk("stop", {cpu_clk_gated_o, phi_o, main_osc_en_o, timers_chained_o}, 4'hD);
    apb(1'h0, oswc_pkg::STATUS_OFS, 32'h0);
    chk("chain load", rd[23:8], 16'h07FF);
    @(posedge clk_i);
    ext_int_pin_i <= 1'h1;
    repeat (6) @(negedge clk_i);
    chk("restart", {cpu_clk_gated_o, main_osc_en_o}, 2'h3);
    @(posedge clk_i);
    ext_int_pin_i <= 1'h0;
    for (n = 7; n < 9000 && cpu_clk_gated_o !== 1'h0; n++) @(negedge clk_i);
    chk("release", n > REL_N - PS && n < REL_N + PS + 12, 1'h1);
    chk("unchained", timers_chained_o, 1'h0);
    $display("test stop done");
    apb(1'h1, oswc_pkg::CPU_MODE_OFS, 32'h1C);
    pulse(3'h2);
    settle();
    chk("wait again", cpu_clk_gated_o, 1'h1);
    @(posedge clk_i);
    rstn_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(negedge clk_i);
    chk("reset wake", cpu_clk_gated_o, 1'h0);
    repeat (3) @(negedge clk_i);
    chk("drive", sub_drive_strong_o, 1'h1);
    apb(1'h0, oswc_pkg::CPU_MODE_OFS, 32'h0);
    chk("cpu mode", rd, 32'h3C);
    $display("test second reset done");
    complete_run();
  end
endmodule

// File: oswc_cpu_model.sv
`timescale 1ns/1ps
module oswc_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Requests: bit0 stop, bit1 wait, bit2 interrupt
  input wire logic [2:0] req_i,
  // Clock control status
  input wire logic gated_i,
  input wire logic resume_i,
  // Strobes and interrupt acceptance
  output logic stop_instr_o,
  output logic wait_instr_o,
  output logic irq_valid_o
);
  // Instructions issue only while the core runs; an accepted interrupt holds until resume.
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      stop_instr_o <= 1'h0;
      wait_instr_o <= 1'h0;
      irq_valid_o <= 1'h0;
    end
    else
    begin
      stop_instr_o <= req_i[0] && !gated_i;
      wait_instr_o <= req_i[1] && !gated_i;
      irq_valid_o <= !resume_i && (irq_valid_o || (req_i[2] && gated_i));
    end
endmodule

// File: oswc_monitor.sv
`timescale 1ns/1ps
module oswc_monitor #(
  parameter int PRESCALE = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Watched inputs
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic stop_instr_i,
  input wire logic wait_instr_i,
  input wire logic irq_valid_i,
  input wire logic ext_int_pin_i,
  // Watched outputs
  input wire logic pready_o,
  input wire logic phi_o,
  input wire logic cpu_clk_gated_o,
  input wire logic main_osc_en_o,
  input wire logic timers_chained_o,
  input wire logic resume_o
);
  localparam int REL_N = PRESCALE * 2048;
  int settle_cnt;
  // Counts settle cycles so the release length can be judged when the chain drops.
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      settle_cnt <= 0;
    else if (!timers_chained_o)
      settle_cnt <= 0;
    else if (main_osc_en_o)
      settle_cnt <= settle_cnt + 1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_STOP_GATE: assert property (stop_instr_i && !cpu_clk_gated_o |=>
    cpu_clk_gated_o && phi_o && !main_osc_en_o && timers_chained_o) else $error("stop entry");
  AST_WAIT_GATE: assert property (wait_instr_i && !stop_instr_i && !cpu_clk_gated_o
    |=> cpu_clk_gated_o && phi_o && !timers_chained_o) else $error("wait entry");
  AST_WAIT_WAKE: assert property (cpu_clk_gated_o && !timers_chained_o
    && irq_valid_i |=> !cpu_clk_gated_o && resume_o) else $error("wait wake late");
  AST_WAIT_BLOCK: assert property ((!irq_valid_i && !ext_int_pin_i)[*4]
    ##0 (cpu_clk_gated_o && !timers_chained_o) |=> cpu_clk_gated_o) else $error("false wake");
  AST_STOP_HOLD: assert property (timers_chained_o |-> cpu_clk_gated_o && phi_o)
    else $error("clock ungated in stop");
  AST_STOP_OSC: assert property ((!ext_int_pin_i)[*4]
    ##0 (timers_chained_o && !main_osc_en_o) |=> !main_osc_en_o) else $error("osc restarted");
  AST_SETTLE_LEN: assert property ($fell(timers_chained_o) |->
    settle_cnt > REL_N - PRESCALE - 4 && settle_cnt < REL_N + PRESCALE + 4)
    else $error("settle length");
  AST_PREADY: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb no answer");
  COV_STOP: cover property ($fell(timers_chained_o));
  COV_WAKE: cover property (cpu_clk_gated_o && irq_valid_i);
  COV_APB: cover property (psel_i && penable_i && pready_o);
endmodule
bind oswc_top oswc_monitor #(.PRESCALE(PRESCALE)) i_mon (.clk_i, .rstn_i, .psel_i, .penable_i,
  .stop_instr_i, .wait_instr_i, .irq_valid_i, .ext_int_pin_i, .pready_o, .phi_o,
  .cpu_clk_gated_o, .main_osc_en_o, .timers_chained_o, .resume_o);

// File: oswc_pkg.sv
// Overview of operation
// - Stop instruction parks CPU clock high and halts the oscillator.
// - Stop instruction chains timer 3 into timer 4, loading FF and 07.
// - External interrupt restarts oscillator; CPU clock held until timer 4 overflows.
// - Wait instruction parks CPU clock high, oscillator keeps running.
// - Wait mode ends on reset, an accepted valid interrupt or the external interrupt pin.
// - Leaving wait mode resumes execution at once, no settling delay.
// - Listed display, bus, converter and fast-divided timer interrupts never wake wait.
// - Main clock stop bit set stops main oscillator, except during release from stop; sub-clock keeps running.
// - Clearing sub oscillator drive bit selects reduced drive strength.
// - Reset sets sub oscillator drive bit, selecting strong drive.
// - Clock source bits 5 and 4 choose sub-clock or display oscillator.
// - Each timer divides its count source by loaded value plus one.
// - After reset the CPU clock runs at half the main oscillator rate.
// - CPU mode bit 7 set switches CPU clock to the sub-clock.
package oswc_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CPU_MODE_OFS = 8'h00;
  localparam logic [7:0] CLK_SRC_OFS = 8'h04;
  localparam logic [7:0] TMR_CFG_OFS = 8'h08;
  localparam logic [7:0] TMR_RELOAD_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LOW_SPEED_BIT = 7;
  localparam int MAIN_STOP_BIT = 6;
  localparam int SUB_DRIVE_BIT = 5;
  localparam int CLK_SRC_LO = 4;
  localparam int T3_SRC_BIT = 0;
  localparam int T3_ALT_BIT = 6;
  localparam int T3_IE_BIT = 1;
  localparam int T4_IE_BIT = 2;
  localparam logic [7:0] CPU_MODE_RST = 8'h3C;
  localparam logic [7:0] CLK_SRC_RST = 8'h00;
  localparam logic [7:0] TMR_CFG_RST = 8'h00;
  localparam logic [7:0] T3_RST = 8'hFF;
  localparam logic [7:0] T4_RST = 8'h07;
  localparam logic [7:0] T3_STOP_LOAD = 8'hFF;
  localparam logic [7:0] T4_STOP_LOAD = 8'h07;
  // ---------------------------------------------------------------
  // Timing and sizes
  // ---------------------------------------------------------------
  localparam int PRESCALE_DIV = 16;
  localparam int WAIT_BLOCK_N = 10;
  typedef enum logic [1:0] {
    OSWC_RUN,
    OSWC_WAIT,
    OSWC_STOP,
    OSWC_SETTLE
  } oswc_state_e;
endpackage

// File: oswc_sync.sv
`timescale 1ns/1ps
module oswc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// File: oswc_timer.sv
`timescale 1ns/1ps
module oswc_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic [7:0] reload_i,
  input wire logic tick_i,
  // Result
  output logic [7:0] count_o,
  output logic ovf_o
);
  // Counts down one step per tick and reloads on the tick at zero.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= 8'h00;
      ovf_o <= 1'b0;
    end
    else
    begin
      ovf_o <= 1'b0;
      if (load_i)
      begin
        count_o <= load_val_i;
      end
      else if (tick_i)
      begin
        if (count_o == 8'h00)
        begin
          count_o <= reload_i;
          ovf_o <= 1'b1;
        end
        else
        begin
          count_o <= count_o - 8'h01;
        end
      end
    end
  end
endmodule

// File: oswc_top.sv
`timescale 1ns/1ps
module oswc_top #(
  parameter int PRESCALE = oswc_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // CPU instruction strobes and interrupt acceptance
  input wire logic stop_instr_i,
  input wire logic wait_instr_i,
  input wire logic irq_valid_i,
  input wire logic [oswc_pkg::WAIT_BLOCK_N-1:0] irq_blocked_i,
  // Pins
  input wire logic ext_int_pin_i,
  input wire logic sub_clk_pin_i,
  // Clock control outputs
  output logic phi_o,
  output logic cpu_clk_gated_o,
  output logic main_osc_en_o,
  output logic sub_drive_strong_o,
  output logic [1:0] clk_src_sel_o,
  output logic timers_chained_o,
  output logic resume_o,
  output logic t3_ovf_o,
  output logic t4_ovf_o
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PRESCALE < 2 || PRESCALE > 256)
  begin : g_bad_prescale
    $error("PRESCALE must lie between 2 and 256");
  end

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  logic ext_int_sync;
  logic sub_clk_sync;

  oswc_sync u_sync_ext (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(ext_int_pin_i),
    .q_o(ext_int_sync)
  );

  oswc_sync u_sync_sub (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(sub_clk_pin_i),
    .q_o(sub_clk_sync)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] cpu_mode_reg;
  logic [7:0] clk_src_reg;
  logic [7:0] tmr_cfg_reg;
  logic [7:0] t3_reload_reg;
  logic [7:0] t4_reload_reg;
  logic [oswc_pkg::WAIT_BLOCK_N-1:0] blocked_seen_reg;
  oswc_pkg::oswc_state_e state_reg;
  oswc_pkg::oswc_state_e state_next;

  function automatic logic [31:0] read_mux(input logic [7:0] addr, input logic [31:0] status);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (addr == oswc_pkg::CPU_MODE_OFS)
    begin
      r = {24'h00_0000, cpu_mode_reg};
    end
    else if (addr == oswc_pkg::CLK_SRC_OFS)
    begin
      r = {24'h00_0000, clk_src_reg};
    end
    else if (addr == oswc_pkg::TMR_CFG_OFS)
    begin
      r = {24'h00_0000, tmr_cfg_reg};
    end
    else if (addr == oswc_pkg::TMR_RELOAD_OFS)
    begin
      r = {16'h0000, t4_reload_reg, t3_reload_reg};
    end
    else if (addr == oswc_pkg::STATUS_OFS)
    begin
      r = status;
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] addr);
    return (addr == oswc_pkg::CPU_MODE_OFS) || (addr == oswc_pkg::CLK_SRC_OFS) ||
           (addr == oswc_pkg::TMR_CFG_OFS) || (addr == oswc_pkg::TMR_RELOAD_OFS) ||
           (addr == oswc_pkg::STATUS_OFS);
  endfunction

  // ---------------------------------------------------------------
  // APB handshake with one wait state
  // ---------------------------------------------------------------
  logic apb_commit;
  logic [7:0] t3_count;
  logic [7:0] t4_count;
  logic [31:0] status_word;

  assign apb_commit = psel_i && penable_i && pready_o;
  assign status_word = {blocked_seen_reg[6:0], |blocked_seen_reg, t4_count, t3_count,
                        main_osc_en_o, cpu_clk_gated_o, timers_chained_o,
                        3'h0, state_reg};

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && penable_i && !pready_o;
      if (psel_i && penable_i && !pready_o)
      begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : read_mux(paddr_i, status_word);
        pslverr_o <= !addr_ok(paddr_i);
      end
      else
      begin
        pslverr_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_mode_reg <= oswc_pkg::CPU_MODE_RST;
      clk_src_reg <= oswc_pkg::CLK_SRC_RST;
      tmr_cfg_reg <= oswc_pkg::TMR_CFG_RST;
      t3_reload_reg <= oswc_pkg::T3_RST;
      t4_reload_reg <= oswc_pkg::T4_RST;
    end
    else if (apb_commit && pwrite_i)
    begin
      if (paddr_i == oswc_pkg::CPU_MODE_OFS)
      begin
        cpu_mode_reg <= pwdata_i[7:0];
      end
      else if (paddr_i == oswc_pkg::CLK_SRC_OFS)
      begin
        clk_src_reg <= pwdata_i[7:0];
      end
      else if (paddr_i == oswc_pkg::TMR_CFG_OFS)
      begin
        tmr_cfg_reg <= pwdata_i[7:0];
      end
      else if (paddr_i == oswc_pkg::TMR_RELOAD_OFS)
      begin
        t3_reload_reg <= pwdata_i[7:0];
        t4_reload_reg <= pwdata_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Power mode state machine
  // ---------------------------------------------------------------
  logic t4_ovf;
  logic wake_wait;

  // Blocked interrupt kinds are not part of this term at all.
  assign wake_wait = irq_valid_i || ext_int_sync;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      oswc_pkg::OSWC_RUN:
      begin
        if (stop_instr_i)
        begin
          state_next = oswc_pkg::OSWC_STOP;
        end
        else if (wait_instr_i)
        begin
          state_next = oswc_pkg::OSWC_WAIT;
        end
      end
      oswc_pkg::OSWC_WAIT:
      begin
        if (wake_wait)
        begin
          state_next = oswc_pkg::OSWC_RUN;
        end
      end
      oswc_pkg::OSWC_STOP:
      begin
        if (ext_int_sync)
        begin
          state_next = oswc_pkg::OSWC_SETTLE;
        end
      end
      oswc_pkg::OSWC_SETTLE:
      begin
        if (t4_ovf)
        begin
          state_next = oswc_pkg::OSWC_RUN;
        end
      end
      default:
      begin
        state_next = oswc_pkg::OSWC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= oswc_pkg::OSWC_RUN;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blocked_seen_reg <= '0;
    end
    else if (state_reg == oswc_pkg::OSWC_WAIT)
    begin
      blocked_seen_reg <= blocked_seen_reg | irq_blocked_i;
    end
    else if (state_next == oswc_pkg::OSWC_WAIT)
    begin
      blocked_seen_reg <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and timers 3 and 4
  // ---------------------------------------------------------------
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  logic [PW-1:0] pre_cnt_reg;
  logic pre_tick;
  logic stop_load;
  logic chained;
  logic t3_tick;
  logic t4_tick;
  logic t3_ovf;

  // The prescaler advances in every state but stop, even with the main clock stop bit set.
  assign pre_tick = (pre_cnt_reg == PRE_LAST) && (state_reg != oswc_pkg::OSWC_STOP);
  assign stop_load = (state_reg == oswc_pkg::OSWC_RUN) && stop_instr_i;
  assign chained = (state_reg == oswc_pkg::OSWC_STOP) || (state_reg == oswc_pkg::OSWC_SETTLE);
  assign t3_tick = pre_tick;
  assign t4_tick = chained ? t3_ovf : pre_tick;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg <= '0;
    end
    else if (stop_load)
    begin
      pre_cnt_reg <= '0;
    end
    else if (state_reg != oswc_pkg::OSWC_STOP)
    begin
      pre_cnt_reg <= (pre_cnt_reg == PRE_LAST) ? '0 : pre_cnt_reg + 1'b1;
    end
  end

  oswc_timer u_timer3 (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(stop_load),
    .load_val_i(oswc_pkg::T3_STOP_LOAD),
    .reload_i(chained ? oswc_pkg::T3_STOP_LOAD : t3_reload_reg),
    .tick_i(t3_tick),
    .count_o(t3_count),
    .ovf_o(t3_ovf)
  );

  oswc_timer u_timer4 (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(stop_load),
    .load_val_i(oswc_pkg::T4_STOP_LOAD),
    .reload_i(chained ? oswc_pkg::T4_STOP_LOAD : t4_reload_reg),
    .tick_i(t4_tick),
    .count_o(t4_count),
    .ovf_o(t4_ovf)
  );

  // ---------------------------------------------------------------
  // Clock outputs
  // ---------------------------------------------------------------
  logic gate_next;

  assign gate_next = state_next != oswc_pkg::OSWC_RUN;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phi_o <= 1'b1;
      cpu_clk_gated_o <= 1'b0;
      main_osc_en_o <= 1'b1;
      sub_drive_strong_o <= 1'b1;
      clk_src_sel_o <= 2'h0;
      timers_chained_o <= 1'b0;
      resume_o <= 1'b0;
      t3_ovf_o <= 1'b0;
      t4_ovf_o <= 1'b0;
    end
    else
    begin
      cpu_clk_gated_o <= gate_next;
      if (gate_next)
      begin
        phi_o <= 1'b1;
      end
      else if (cpu_mode_reg[oswc_pkg::LOW_SPEED_BIT])
      begin
        phi_o <= sub_clk_sync;
      end
      else
      begin
        phi_o <= !phi_o;
      end
      // Stop halts the oscillator; the main clock stop bit only holds outside release.
      main_osc_en_o <= (state_next != oswc_pkg::OSWC_STOP) &&
                       ((state_next == oswc_pkg::OSWC_SETTLE) ||
                        !cpu_mode_reg[oswc_pkg::MAIN_STOP_BIT]);
      sub_drive_strong_o <= cpu_mode_reg[oswc_pkg::SUB_DRIVE_BIT];
      clk_src_sel_o <= clk_src_reg[oswc_pkg::CLK_SRC_LO+1:oswc_pkg::CLK_SRC_LO];
      timers_chained_o <= (state_next == oswc_pkg::OSWC_STOP) ||
                          (state_next == oswc_pkg::OSWC_SETTLE);
      resume_o <= (state_reg != oswc_pkg::OSWC_RUN) &&
                  (state_next == oswc_pkg::OSWC_RUN);
      // Interrupt requests stay quiet while chained so release cannot raise them.
      t3_ovf_o <= t3_ovf && !chained && tmr_cfg_reg[oswc_pkg::T3_IE_BIT];
      t4_ovf_o <= t4_ovf && !chained && tmr_cfg_reg[oswc_pkg::T4_IE_BIT];
    end
  end
endmodule
